// ### shared/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Conversion result width
`define ADC_DATA_W 10

// Register byte offsets
`define OFF_MODE_REG_0 8'h00
`define OFF_MODE_REG_1 8'h04
`define OFF_MODE_REG_2 8'h08
`define OFF_MODE_REG_3 8'h0C
`define OFF_MODE_REG_4 8'h10
`define OFF_SCAN_CONFIG_REG 8'h14
`define OFF_RESULT_REG_BASE 8'h20
`define OFF_PRIORITY_RESULT_REG 8'h40

// mode_reg_0 fields
`define B_NORMAL_START 0
`define B_SCAN_SEL 1
`define B_REPEAT_SEL 2
`define B_ITM_LO 3
`define B_ITM_HI 4
`define B_NORMAL_BUSY 5
`define B_NORMAL_DONE 6

// mode_reg_2 fields
`define B_PCH_LO 0
`define B_PCH_HI 2
`define B_PRIORITY_START 3
`define B_PRIORITY_BUSY 4
`define B_PRIORITY_DONE 5

// mode_reg_3 fields
`define B_SOFT_RESET 0

// mode_reg_4 fields
`define B_NORMAL_HW_SRC 0
`define B_NORMAL_HW_EN 1
`define B_PRIORITY_HW_SRC 2
`define B_PRIORITY_HW_EN 3

// Reset values
`define RST_MODE_SEL 2'h0
`define RST_CH_SEL 4'h0

// Interval select codes
`define ITM_EVERY_1 2'h0
`define ITM_EVERY_4 2'h1
`define ITM_EVERY_8 2'h2

// Rotating result set last index per interval
`define ROT_LAST_4 3'h3
`define ROT_LAST_8 3'h7

// Priority result slot in the result array
`define PRIO_SLOT 8

// Default conversion time in clock cycles
`define CONV_CYCLES_DEF 40

`endif

// ### shared/adc_seq_pkg.sv
`include "adc_seq_map.svh"

package adc_seq_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NORM = 2'b01,
		ST_PRIO = 2'b10
	} conv_state_e;

	typedef logic [`ADC_DATA_W-1:0] sample_t;

	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

	// Complete sequencer state
	typedef struct packed {
		conv_state_e state;
		logic [15:0] cnt;
		logic [2:0] cur_ch;
		logic [2:0] conv_ch;
		logic [2:0] scan_left;
		logic [2:0] rot;
		logic scan_sel;
		logic repeat_sel;
		logic [1:0] itm;
		logic [3:0] ch_sel;
		logic [2:0] pch;
		logic [2:0] scan_cfg;
		logic n_src;
		logic n_en;
		logic p_src;
		logic p_en;
		logic n_busy;
		logic n_done;
		logic p_busy;
		logic p_done;
		logic run_rep;
		logic ext_prev;
		logic n_irq;
		logic p_irq;
		logic [31:0] rdata;
		logic [8:0][`ADC_DATA_W-1:0] res;
	} seq_state_s;

endpackage

// ### test/adc_conversion_sequencer_tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t mismatch", $time); end end

module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, ext_n, t5, t6, act, nirq, pirq;
	reg_req_s q;
	sample_t ain;
	logic [31:0] rdata, v;
	logic [2:0] sel;
	int errors, compares, n, c;
	adc_conversion_sequencer #(.CONV_CYCLES(4)) dut (
		.i_clk_sys(clk), .i_rst(rst), .i_req(q), .o_rdata(rdata), .i_ain_data(ain),
		.o_ain_sel(sel), .o_conv_active(act), .i_external_trigger_n(ext_n),
		.i_timer6_compare_event(t6), .i_timer5_compare_event(t5),
		.o_normal_done_irq(nirq), .o_priority_done_irq(pirq)
	);
	// Sample tracks the selected channel
	always @(posedge clk) ain <= {7'h2A, sel};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] ev(input logic [2:0] k);
		return {22'h0, 7'h2A, k};
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		q <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		q <= '0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		q <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		q <= '0;
		@(negedge clk);
		v = rdata;
	endtask
	// Bounded wait for a completion pulse
	task wt(input logic p);
		n = 0;
		@(negedge clk);
		while (!(p ? pirq : nirq) && n < 300) begin
			@(negedge clk);
			n++;
		end
		`CHK(n < 300, 1'b1)
	endtask
	task pulse5;
		@(posedge clk);
		t5 <= 1'b1;
		@(posedge clk);
		t5 <= 1'b0;
	endtask
	task pulse6;
		@(posedge clk);
		t6 <= 1'b1;
		@(posedge clk);
		t6 <= 1'b0;
	endtask
	task summarize;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		q = '0;
		ext_n = 1'b1;
		t5 = 1'b0;
		t6 = 1'b0;
		ain = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00);
		`CHK(v, 32'h0)
		rd(8'h04);
		`CHK(v, 32'h0)
		rd(8'h18);
		`CHK(v, 32'h0)
		// Fixed single on channel 3
		wr(8'h04, 32'h3);
		wr(8'h00, 32'h1);
		rd(8'h00);
		`CHK(v, 32'h20)
		wt(1'b0);
		rd(8'h00);
		`CHK(v, 32'h40)
		rd(8'h00);
		`CHK(v, 32'h0)
		rd(8'h2C);
		`CHK(v, ev(3'h3))
		// Scan single 6, 7, 0
		wr(8'h04, 32'h6);
		wr(8'h14, 32'h2);
		wr(8'h00, 32'h3);
		wt(1'b0);
		`CHK(n > 8, 1'b1)
		rd(8'h00);
		`CHK(v, 32'h42)
		for (int k = 6; k < 9; k++) begin
			rd(8'h20 + {3'h0, 3'(k), 2'h0});
			`CHK(v, ev(3'(k)))
		end
		// Priority preempts channel 1
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h1);
		wr(8'h08, 32'hD);
		rd(8'h00);
		`CHK(v[6:5], 2'b01)
		wt(1'b1);
		rd(8'h40);
		`CHK(v, ev(3'h5))
		wt(1'b0);
		rd(8'h24);
		`CHK(v, ev(3'h1))
		// Fixed repeat over every interval
		for (int m = 0; m < 3; m++) begin
			c = (m == 0) ? 1 : 4 * m;
			wr(8'h04, 32'(4 + m));
			wr(8'h00, 32'h5 | 32'(m << 3));
			wt(1'b0);
			`CHK(n > 4 * c - 5, 1'b1)
			rd(8'h00);
			`CHK(v[6:5], 2'b11)
			for (int k = 0; k < c; k++) begin
				rd(8'h20 + 8'(4 * k));
				`CHK(v, ev(3'(4 + m)))
			end
			if (m == 0) begin
				rd(8'h24);
				`CHK(v, ev(3'h1))
			end
			wr(8'h00, 32'h0);
			repeat (8) @(posedge clk);
			rd(8'h00);
			`CHK(v[5], 1'b0)
		end
		// Timer trigger gated, then taken
		wr(8'h10, 32'h4);
		pulse5();
		@(negedge clk);
		`CHK(act, 1'b0)
		wr(8'h10, 32'hC);
		wr(8'h08, 32'h3);
		pulse5();
		wt(1'b1);
		rd(8'h40);
		`CHK(v, ev(3'h3))
		rd(8'h08);
		`CHK(v[5:4], 2'b10)
		rd(8'h08);
		`CHK(v[5], 1'b0)
		// External falling edge, then software start
		wr(8'h10, 32'h2);
		wr(8'h04, 32'h7);
		@(posedge clk);
		ext_n <= 1'b0;
		repeat (2) @(posedge clk);
		ext_n <= 1'b1;
		wt(1'b0);
		rd(8'h3C);
		`CHK(v, ev(3'h7))
		wr(8'h04, 32'h5);
		wr(8'h00, 32'h1);
		wt(1'b0);
		rd(8'h34);
		`CHK(v, ev(3'h5))
		// Timer 6 trigger for normal conversion
		wr(8'h10, 32'h3);
		wr(8'h04, 32'h2);
		pulse6();
		wt(1'b0);
		rd(8'h28);
		`CHK(v, ev(3'h2))
		// Second priority start while one runs is ignored
		wr(8'h08, 32'hE);
		wr(8'h08, 32'hB);
		wt(1'b1);
		rd(8'h40);
		`CHK(v, ev(3'h6))
		// Scan repeat over channels 0 and 1, stopped by soft reset
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h1);
		wr(8'h00, 32'h7);
		wt(1'b0);
		rd(8'h00);
		`CHK(v[6:5], 2'b11)
		wt(1'b0);
		`CHK(n < 12, 1'b1)
		wr(8'h0C, 32'h1);
		rd(8'h00);
		`CHK(v[5], 1'b0)
		rd(8'h24);
		`CHK(v, ev(3'h1))
		summarize();
	end
endmodule

// ### test/adc_seq_props.sv
module adc_seq_props
	import adc_seq_pkg::*;
#(
	parameter int CONV_CYCLES = 4
) (
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst, // Reset
	input wire reg_req_s i_req, // Bus
	input wire logic [31:0] o_rdata, // Read data
	input wire sample_t i_ain_data, // Sample
	input wire logic [2:0] o_ain_sel, // Channel
	input wire logic o_conv_active, // Active
	input wire logic i_external_trigger_n, // Pin
	input wire logic i_timer6_compare_event, // Timer 6
	input wire logic i_timer5_compare_event, // Timer 5
	input wire logic o_normal_done_irq, // Irq
	input wire logic o_priority_done_irq // Irq
);
	localparam int PLO = CONV_CYCLES;
	localparam int PHI = CONV_CYCLES + 2;
	logic pen_r;
	logic psrc_r;
	logic [2:0] pch_r;
	logic pgo;
	logic ngo;
	// Start writes while idle
	assign pgo = i_req.wr && i_req.addr == 8'h08 && i_req.wdata[3] && !o_conv_active;
	assign ngo = i_req.wr && i_req.addr == 8'h00 && i_req.wdata[0] && !o_conv_active;
	// Shadow of the priority setup
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pen_r <= 1'b0;
			psrc_r <= 1'b0;
			pch_r <= 3'h0;
		end else begin
			if (i_req.wr && i_req.addr == 8'h10) begin
				pen_r <= i_req.wdata[3];
				psrc_r <= i_req.wdata[2];
			end
			if (i_req.wr && i_req.addr == 8'h08) begin
				pch_r <= i_req.wdata[2:0];
			end
		end
	end
	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	a_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0)
		else $error("read data out of slot");
	a_nstart_busy: assert property (ngo |=> o_conv_active)
		else $error("normal start lost");
	a_pstart_done: assert property (pgo |-> ##[PLO:PHI] o_priority_done_irq)
		else $error("priority done late");
	a_psel_chan: assert property (pgo |=> ##1 o_ain_sel == pch_r)
		else $error("priority channel wrong");
	a_ptimer_trig: assert property (pen_r && psrc_r && i_timer5_compare_event |=> o_conv_active)
		else $error("timer trigger lost");
	a_conv_len: assert property ($rose(o_conv_active) |-> o_conv_active[*4])
		else $error("conversion cut short");
	a_nirq_pulse: assert property (o_normal_done_irq |=> !o_normal_done_irq)
		else $error("normal irq too long");
	a_pirq_cause: assert property (o_priority_done_irq |-> $past(o_conv_active) && !$past(o_priority_done_irq))
		else $error("priority irq stray");
	c_norm_done: cover property ($rose(o_normal_done_irq));
	c_prio_done: cover property (o_priority_done_irq);
	c_timer_trig: cover property (pen_r && i_timer5_compare_event);
endmodule

bind adc_conversion_sequencer adc_seq_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
	.i_clk_sys, .i_rst, .i_req, .o_rdata, .i_ain_data, .o_ain_sel, .o_conv_active,
	.i_external_trigger_n, .i_timer6_compare_event, .i_timer5_compare_event,
	.o_normal_done_irq, .o_priority_done_irq
);

// ### verilog/adc_conversion_sequencer.sv
// How it works
// - Reset clears repeat and scan selects and the four-bit channel select.
// - Scan select 0 converts the one channel named by the channel select.
// - Scan select 1 steps through channels from channel select, length from scan config.
// - Priority conversion converts the channel named by the priority channel select.
// - Writing 1 to a start bit begins that conversion type.
// - Priority conversion is always fixed-channel single, ignoring mode selects.
// - Source select 0 uses external falling edge; 1 uses timer 6 or timer 5.
// - Hardware triggers act only while their enable bit is 1.
// - Software start writes still work with hardware triggering enabled.
// - Normal start sets the normal busy flag.
// - Priority start sets priority busy and leaves normal busy and done alone.
// - Priority start suspends normal work, converts, stores, then normal resumes.
// - After preemption the interrupted channel is converted again.
// - Clearing repeat finishes the current conversion, then stops and clears busy.
// - Except fixed repeat and priority, each result goes to its channel's result register.
// - Fixed single completion sets done, clears busy, raises the interrupt.
// - Scan single sets done, clears busy, interrupts after the whole scan.
// - Fixed repeat keeps busy; interval 00 fires each time into register 0.
// - Interval 01 rotates registers 0..3, 10 rotates 0..7, firing on wrap.
// - Scan repeat sets done and interrupts per scan, busy stays 1.
// - Reading a done flag clears it.
// - Priority completion interrupts, sets priority done, clears priority busy.
// - A priority start during a priority conversion is ignored.
module adc_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES_DEF
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire reg_req_s i_req, // Register bus request
	output logic [31:0] o_rdata, // Read data, cycle after read
	input wire sample_t i_ain_data, // Converter sample value
	output logic [2:0] o_ain_sel, // Analog channel being converted
	output logic o_conv_active, // Conversion in progress
	input wire logic i_external_trigger_n, // External trigger pin, low active
	input wire logic i_timer6_compare_event, // Timer 6 compare pulse
	input wire logic i_timer5_compare_event, // Timer 5 compare pulse
	output logic o_normal_done_irq, // Normal completion pulse
	output logic o_priority_done_irq // Priority completion pulse
);

	localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES);

	seq_state_s r;
	seq_state_s n;

	// Next state
	always_comb begin
		logic ext_fall;
		logic sw_n_start;
		logic sw_p_start;
		logic soft_rst;
		logic hw_n;
		logic hw_p;
		logic last;
		logic [2:0] idx;
		ext_fall = 1'b0;
		sw_n_start = 1'b0;
		sw_p_start = 1'b0;
		soft_rst = 1'b0;
		hw_n = 1'b0;
		hw_p = 1'b0;
		last = 1'b0;
		idx = 3'h0;
		n = r;
		n.n_irq = 1'b0;
		n.p_irq = 1'b0;
		n.rdata = 32'h0;
		n.ext_prev = i_external_trigger_n;

		// Register reads, done flags clear on read
		if (i_req.rd) begin
			case (i_req.addr)
				`OFF_MODE_REG_0: begin
					n.rdata[`B_SCAN_SEL] = r.scan_sel;
					n.rdata[`B_REPEAT_SEL] = r.repeat_sel;
					n.rdata[`B_ITM_HI:`B_ITM_LO] = r.itm;
					n.rdata[`B_NORMAL_BUSY] = r.n_busy;
					n.rdata[`B_NORMAL_DONE] = r.n_done;
					n.n_done = 1'b0;
				end
				`OFF_MODE_REG_1: n.rdata[3:0] = r.ch_sel;
				`OFF_MODE_REG_2: begin
					n.rdata[`B_PCH_HI:`B_PCH_LO] = r.pch;
					n.rdata[`B_PRIORITY_BUSY] = r.p_busy;
					n.rdata[`B_PRIORITY_DONE] = r.p_done;
					n.p_done = 1'b0;
				end
				`OFF_MODE_REG_4: begin
					n.rdata[`B_NORMAL_HW_SRC] = r.n_src;
					n.rdata[`B_NORMAL_HW_EN] = r.n_en;
					n.rdata[`B_PRIORITY_HW_SRC] = r.p_src;
					n.rdata[`B_PRIORITY_HW_EN] = r.p_en;
				end
				`OFF_SCAN_CONFIG_REG: n.rdata[2:0] = r.scan_cfg;
				`OFF_PRIORITY_RESULT_REG: n.rdata[`ADC_DATA_W-1:0] = r.res[`PRIO_SLOT];
				default: begin
					if (i_req.addr >= `OFF_RESULT_REG_BASE && i_req.addr < `OFF_PRIORITY_RESULT_REG
						&& i_req.addr[1:0] == 2'h0) begin
						n.rdata[`ADC_DATA_W-1:0] = r.res[i_req.addr[4:2]];
					end
				end
			endcase
		end

		// Register writes
		if (i_req.wr) begin
			case (i_req.addr)
				`OFF_MODE_REG_0: begin
					n.scan_sel = i_req.wdata[`B_SCAN_SEL];
					n.repeat_sel = i_req.wdata[`B_REPEAT_SEL];
					n.itm = i_req.wdata[`B_ITM_HI:`B_ITM_LO];
					sw_n_start = i_req.wdata[`B_NORMAL_START];
				end
				`OFF_MODE_REG_1: n.ch_sel = i_req.wdata[3:0];
				`OFF_MODE_REG_2: begin
					n.pch = i_req.wdata[`B_PCH_HI:`B_PCH_LO];
					sw_p_start = i_req.wdata[`B_PRIORITY_START];
				end
				`OFF_MODE_REG_3: soft_rst = i_req.wdata[`B_SOFT_RESET];
				`OFF_MODE_REG_4: begin
					n.n_src = i_req.wdata[`B_NORMAL_HW_SRC];
					n.n_en = i_req.wdata[`B_NORMAL_HW_EN];
					n.p_src = i_req.wdata[`B_PRIORITY_HW_SRC];
					n.p_en = i_req.wdata[`B_PRIORITY_HW_EN];
				end
				`OFF_SCAN_CONFIG_REG: n.scan_cfg = i_req.wdata[2:0];
				default: begin
				end
			endcase
		end

		// Hardware trigger selection and gating
		ext_fall = r.ext_prev & ~i_external_trigger_n;
		hw_n = r.n_en & (r.n_src ? i_timer6_compare_event : ext_fall);
		hw_p = r.p_en & (r.p_src ? i_timer5_compare_event : ext_fall);

		// Conversion timing and completion
		if (r.state != ST_IDLE) begin
			n.cnt = r.cnt - 16'h1;
		end
		if (r.state == ST_PRIO && r.cnt == 16'h1) begin
			n.res[`PRIO_SLOT] = i_ain_data;
			n.p_done = 1'b1;
			n.p_irq = 1'b1;
			n.p_busy = 1'b0;
			if (r.n_busy) begin
				n.state = ST_NORM;
				n.cnt = CONV_LOAD;
			end else begin
				n.state = ST_IDLE;
			end
		end
		if (r.state == ST_NORM && r.cnt == 16'h1) begin
			if (r.repeat_sel && !r.scan_sel) begin
				// Fixed repeat rotating storage
				idx = (r.itm == `ITM_EVERY_1) ? 3'h0 : r.rot;
				n.res[idx] = i_ain_data;
				case (r.itm)
					`ITM_EVERY_4: last = (r.rot == `ROT_LAST_4);
					`ITM_EVERY_8: last = (r.rot == `ROT_LAST_8);
					default: last = 1'b1;
				endcase
				n.rot = last ? 3'h0 : r.rot + 3'h1;
				if (last) begin
					n.n_done = 1'b1;
					n.n_irq = 1'b1;
				end
				n.cnt = CONV_LOAD;
			end else begin
				n.res[r.cur_ch] = i_ain_data;
				if (r.scan_sel && r.scan_left != 3'h0) begin
					n.cur_ch = r.cur_ch + 3'h1;
					n.scan_left = r.scan_left - 3'h1;
					n.cnt = CONV_LOAD;
				end else begin
					n.n_done = 1'b1;
					n.n_irq = 1'b1;
					n.cur_ch = r.ch_sel[2:0];
					n.scan_left = r.scan_cfg;
					n.cnt = CONV_LOAD;
				end
			end
			// Stop unless repeat is still selected or a single scan has channels left
			if (!r.repeat_sel) begin
				if (r.run_rep || !r.scan_sel || r.scan_left == 3'h0) begin
					n.n_busy = 1'b0;
					n.run_rep = 1'b0;
					n.state = ST_IDLE;
				end
			end
		end

		// Soft reset aborts normal work
		if (soft_rst) begin
			n.n_busy = 1'b0;
			n.run_rep = 1'b0;
			n.rot = 3'h0;
			if (r.state == ST_NORM) begin
				n.state = ST_IDLE;
			end
		end

		// Normal start, refused while either conversion is busy
		if ((sw_n_start || hw_n) && !r.n_busy && !r.p_busy && !soft_rst) begin
			n.n_busy = 1'b1;
			n.run_rep = n.repeat_sel;
			n.cur_ch = n.ch_sel[2:0];
			n.scan_left = n.scan_sel ? n.scan_cfg : 3'h0;
			n.rot = 3'h0;
			n.state = ST_NORM;
			n.cnt = CONV_LOAD;
		end

		// Priority start preempts, ignored while one runs
		if ((sw_p_start || hw_p) && !r.p_busy) begin
			n.p_busy = 1'b1;
			n.conv_ch = n.pch;
			n.state = ST_PRIO;
			n.cnt = CONV_LOAD;
		end

		// Channel driven to the converter
		if (n.state != ST_PRIO) begin
			n.conv_ch = n.cur_ch;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r <= '0;
			r.state <= ST_IDLE;
			r.scan_sel <= 1'(`RST_MODE_SEL >> 1);
			r.repeat_sel <= 1'b0;
			r.ch_sel <= `RST_CH_SEL;
			r.ext_prev <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs
	assign o_rdata = r.rdata;
	assign o_ain_sel = r.conv_ch;
	assign o_conv_active = (r.state != ST_IDLE);
	assign o_normal_done_irq = r.n_irq;
	assign o_priority_done_irq = r.p_irq;

endmodule
